// File: modulator_model.sv
// Partner: behavioural sigma-delta modulator holding mid-scale
module modulator_model #(
	parameter int DIV_CYCLES = 100 // System cycles per modulator bit
)(
	input wire logic sys_clk, // System clock
	input wire logic rst, // Reset, active high
	output logic mod_bit // Modulator bit
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt_q;
	// Alternating bits give a zero mean, so the filter output stays near zero
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			cnt_q <= 0;
			mod_bit <= 1'b0;
		end
		else if (cnt_q == DIV_CYCLES - 1)
		begin
			cnt_q <= 0;
			mod_bit <= ~mod_bit;
		end
		else
			cnt_q <= cnt_q + 1;
	end
endmodule

// File: pressure_dsp_pkg.sv
// Package: constants, register map, self-test codes and filter coefficients of the pressure DSP
package pressure_dsp_pkg;

	// ------------------------------------------------------------
	// Clocking and timing
	// ------------------------------------------------------------
	localparam int SYS_CLK_HZ = 100_000_000;
	localparam int MOD_CLK_HZ = 1_000_000;
	localparam int MOD_DIV_CYCLES = SYS_CLK_HZ / MOD_CLK_HZ;
	localparam int TEST_REPEAT_US = 1000;
	localparam int TEST_REPEAT_CYCLES = TEST_REPEAT_US * (SYS_CLK_HZ / 1_000_000);

	// ------------------------------------------------------------
	// Signal path sizes
	// ------------------------------------------------------------
	localparam int SAMPLE_W = 16;
	localparam int SINC1_RATIO = 24;
	localparam int SINC2_RATIO = 4;
	localparam int IIR_FRAC = 30;
	localparam int IIR_GUARD = 8;
	localparam int TRIM_GAIN_FRAC = 14;
	localparam int TRIM_QUAD_FRAC = 15;
	localparam int TRIM_TCO_FRAC = 8;
	localparam logic signed [15:0] FULL_SCALE = 16'sh7FFF;

	// ------------------------------------------------------------
	// Register map (byte offsets) and fields
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CONFIG5 = 8'h00;
	localparam logic [7:0] OFS_LOCK = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_SENSE = 8'h0C;
	localparam logic [7:0] OFS_TRIM_OFS = 8'h10;
	localparam logic [7:0] OFS_TRIM_GAIN = 8'h14;
	localparam logic [7:0] OFS_TRIM_QUAD = 8'h18;
	localparam logic [7:0] OFS_TRIM_TCO = 8'h1C;
	localparam logic [7:0] OFS_CM_LIMIT = 8'h20;
	localparam logic [7:0] OFS_CM_ERR_LIMIT = 8'h24;
	localparam int SEL_MSB = 3;
	localparam int LPF_SEL_BIT = 4;
	localparam int LOCK_BIT = 0;
	localparam int ST_RUN_BIT = 0;
	localparam int ST_FAIL_BIT = 1;
	localparam int ST_CM_FAULT_BIT = 2;
	localparam int ST_UV_BIT = 3;
	localparam logic [3:0] SEL_RST = 4'h0;
	localparam logic [15:0] TRIM_OFS_RST = 16'h0000;
	localparam logic [15:0] TRIM_GAIN_RST = 16'h4000;
	localparam logic [15:0] TRIM_QUAD_RST = 16'h0000;
	localparam logic [15:0] TRIM_TCO_RST = 16'h0000;
	localparam logic [15:0] CM_LIMIT_RST = 16'h1000;
	localparam logic [15:0] CM_ERR_LIMIT_RST = 16'h2000;

	// ------------------------------------------------------------
	// Self-test codes and injected values
	// ------------------------------------------------------------
	localparam logic [3:0] SEL_CM_TEST = 4'h1;
	localparam logic [1:0] SEL_GRP_DIGITAL = 2'b11;
	localparam logic [1:0] SEL_GRP_FIXED = 2'b01;
	localparam logic [15:0] INJ_VALUE [4] = '{16'h8171, 16'h6C95, 16'h807A, 16'h78AC};
	localparam logic [15:0] FIXED_VALUE [4] = '{16'h0000, 16'hAAAA, 16'h5555, 16'hFFFF};

	typedef enum {CM_IDLE, CM_RUN, CM_FINISH} cm_state_e;

	// ------------------------------------------------------------
	// Low-pass coefficients: a0, n11..n13, n21..n23, d12, d13, d22, d23
	// ------------------------------------------------------------
	localparam real LPF_COEF [2][11] = '{
		'{0.088642612609670, 0.029638050039039, 0.087543281056143, 0.029695285913601,
			0.250241278804809, 0.499999767379068, 0.249758953816089,
			-1.422792640957290, 0.511435253566960, -1.503329908017845, 0.621996524706640},
		'{0.129604264748411, 0.043719804402508, 0.087543281056143, 0.043823599710731,
			0.250296586927511, 0.499999648540934, 0.249703764531484,
			-1.300502656562698, 0.430106921311110, -1.379959571988366, 0.555046257157745}};
	localparam int C_NORM = 11;

	typedef logic signed [31:0] coef_set_t [12];

	function automatic logic signed [31:0] q30(input real r);
		return 32'($rtoi(r * (2.0 ** IIR_FRAC) + ((r < 0.0) ? -0.5 : 0.5)));
	endfunction

	// Last entry rescales the cascade to unity gain at DC
	function automatic coef_set_t coef_q30(input int s);
		real dc;
		coef_set_t c;
		dc = LPF_COEF[s][0] * (LPF_COEF[s][1] + LPF_COEF[s][2] + LPF_COEF[s][3])
			/ (1.0 + LPF_COEF[s][7] + LPF_COEF[s][8])
			* (LPF_COEF[s][4] + LPF_COEF[s][5] + LPF_COEF[s][6])
			/ (1.0 + LPF_COEF[s][9] + LPF_COEF[s][10]);
		for (int j = 0; j < 11; j++)
			c[j] = q30(LPF_COEF[s][j]);
		c[C_NORM] = q30(1.0 / dc);
		return c;
	endfunction

	function automatic logic signed [15:0] sat16(input longint v);
		if (v > longint'(FULL_SCALE))
			return FULL_SCALE;
		if (v < -longint'(FULL_SCALE) - 1)
			return -FULL_SCALE - 16'sh0001;
		return 16'(v);
	endfunction

endpackage

// File: pressure_signal_path_dsp.sv
// Pressure signal path: decimation, trim, low-pass, self-test and register slave
// Summary of operation
// - Four-bit config field selects self-test connection.
// - Lock bit forces select to zero, blocks select writes.
// - Common-mode test sets running, clears fail, compares.
// - Common-mode test repeats every interval while selected.
// - After deselect, final fail result, then running clears.
// - Digital codes one, two inject 8171h, 6C95h.
// - Digital codes three, four inject 807Ah, 78ACh.
// - Injection sets running; accepted only before lock.
// - Fixed codes one, two hold 0000h, AAAAh.
// - Fixed codes three, four hold 5555h, FFFFh.
// - Input is 1 MHz second-order modulator bitstream.
// - Two sinc3 decimators, ratios 24 and 4.
// - Trim offset, sensitivity, nonlinearity over temperature.
// - Low-pass: gain then two biquad sections.
// - 800 Hz coefficient set as tabulated.
// - 1000 Hz coefficient set as tabulated.
// - Undervoltage on any supply aborts serial transactions.
// - Common-mode fault bit follows live comparison.
module pressure_signal_path_dsp
	import pressure_dsp_pkg::*;
#(
	parameter int REPEAT_CYCLES = TEST_REPEAT_CYCLES, // Common-mode test interval in cycles
	parameter int DIV_CYCLES = MOD_DIV_CYCLES // System cycles per modulator bit
)(
	input wire logic sys_clk, // 100 MHz system clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic mod_bit, // Modulator bitstream
	input wire logic signed [7:0] temperature, // Die temperature word
	input wire logic signed [15:0] cm_level, // Transducer common-mode measurement
	input wire logic uv_vcc, // External supply below threshold
	input wire logic uv_vreg, // Digital regulator below threshold
	input wire logic uv_vrega, // Analog regulator below threshold
	input wire logic [7:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte enables
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Wait request
	output logic [15:0] sense_result, // Absolute pressure channel result
	output logic test_running_flag, // Self-test running
	output logic test_fail_flag, // Common-mode self-test failed
	output logic common_mode_fault_bit, // Live common-mode fault
	output logic serial_abort // Serial transactions terminated
);
	localparam coef_set_t LPF_Q [2] = '{coef_q30(0), coef_q30(1)};
	localparam int DIV_W = $clog2(DIV_CYCLES);
	localparam int REP_W = $clog2(REPEAT_CYCLES + 1);

	typedef logic signed [39:0] iir_t;

	function automatic iir_t cmul(input logic signed [31:0] c, input iir_t v);
		// Rounded: a truncation bias would be multiplied by the feedback gain
		return iir_t'((longint'(c) * longint'(v) + (longint'(1) <<< (IIR_FRAC - 1))) >>> IIR_FRAC);
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [15:0] m;
		m = {{8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (wd[15:0] & m);
	endfunction

	// ------------------------------------------------------------
	// Register slave
	// ------------------------------------------------------------
	logic ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic [3:0] sel_q, sel_d;
	logic lpf_1000_q, lpf_1000_d;
	logic lock_q, lock_d;
	logic [15:0] trim_ofs_q, trim_ofs_d, trim_gain_q, trim_gain_d;
	logic [15:0] trim_quad_q, trim_quad_d, trim_tco_q, trim_tco_d;
	logic [15:0] cm_lim_q, cm_lim_d, cm_err_lim_q, cm_err_lim_d;
	logic [15:0] sense_q, sense_d;
	logic run_q, run_d, fail_q, fail_d, fault_q, fault_d, uv_q, uv_d;
	logic commit;

	assign commit = avs_write & ack_q;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

	always_comb
	begin
		ack_d = (avs_read | avs_write) & ~ack_q;
		rdata_d = rdata_q;
		sel_d = sel_q;
		lpf_1000_d = lpf_1000_q;
		lock_d = lock_q;
		trim_ofs_d = trim_ofs_q;
		trim_gain_d = trim_gain_q;
		trim_quad_d = trim_quad_q;
		trim_tco_d = trim_tco_q;
		cm_lim_d = cm_lim_q;
		cm_err_lim_d = cm_err_lim_q;
		if (avs_read & ~ack_q)
		begin
			unique case (avs_address)
				OFS_CONFIG5: rdata_d = {27'h0, lpf_1000_q, sel_q};
				OFS_LOCK: rdata_d = {31'h0, lock_q};
				OFS_STATUS: rdata_d = {28'h0, uv_q, fault_q, fail_q, run_q};
				OFS_SENSE: rdata_d = {16'h0, sense_q};
				OFS_TRIM_OFS: rdata_d = {16'h0, trim_ofs_q};
				OFS_TRIM_GAIN: rdata_d = {16'h0, trim_gain_q};
				OFS_TRIM_QUAD: rdata_d = {16'h0, trim_quad_q};
				OFS_TRIM_TCO: rdata_d = {16'h0, trim_tco_q};
				OFS_CM_LIMIT: rdata_d = {16'h0, cm_lim_q};
				OFS_CM_ERR_LIMIT: rdata_d = {16'h0, cm_err_lim_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
		if (commit)
		begin
			unique case (avs_address)
				OFS_CONFIG5:
				begin
					if (avs_byteenable[0])
					begin
						if (!lock_q)
							sel_d = avs_writedata[SEL_MSB:0];
						lpf_1000_d = avs_writedata[LPF_SEL_BIT];
					end
				end
				OFS_LOCK: lock_d = lock_q | (avs_byteenable[0] & avs_writedata[LOCK_BIT]);
				OFS_TRIM_OFS: trim_ofs_d = merge16(trim_ofs_q, avs_writedata, avs_byteenable);
				OFS_TRIM_GAIN: trim_gain_d = merge16(trim_gain_q, avs_writedata, avs_byteenable);
				OFS_TRIM_QUAD: trim_quad_d = merge16(trim_quad_q, avs_writedata, avs_byteenable);
				OFS_TRIM_TCO: trim_tco_d = merge16(trim_tco_q, avs_writedata, avs_byteenable);
				OFS_CM_LIMIT: cm_lim_d = merge16(cm_lim_q, avs_writedata, avs_byteenable);
				OFS_CM_ERR_LIMIT:
					cm_err_lim_d = merge16(cm_err_lim_q, avs_writedata, avs_byteenable);
				default: ;
			endcase
		end
		if (lock_q)
			sel_d = SEL_RST;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			sel_q <= SEL_RST;
			lpf_1000_q <= 1'b0;
			lock_q <= 1'b0;
			trim_ofs_q <= TRIM_OFS_RST;
			trim_gain_q <= TRIM_GAIN_RST;
			trim_quad_q <= TRIM_QUAD_RST;
			trim_tco_q <= TRIM_TCO_RST;
			cm_lim_q <= CM_LIMIT_RST;
			cm_err_lim_q <= CM_ERR_LIMIT_RST;
		end
		else
		begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
			sel_q <= sel_d;
			lpf_1000_q <= lpf_1000_d;
			lock_q <= lock_d;
			trim_ofs_q <= trim_ofs_d;
			trim_gain_q <= trim_gain_d;
			trim_quad_q <= trim_quad_d;
			trim_tco_q <= trim_tco_d;
			cm_lim_q <= cm_lim_d;
			cm_err_lim_q <= cm_err_lim_d;
		end
	end

	assign avs_readdata = rdata_q;

	// ------------------------------------------------------------
	// Modulator sampling and decimation
	// ------------------------------------------------------------
	logic [DIV_W-1:0] div_q, div_d;
	logic bit_vld_q, bit_vld_d;
	logic signed [15:0] bit_dat_q, bit_dat_d;
	logic is_inj, is_fix, is_cm;

	sample_if #(.W(SAMPLE_W)) bit_s();
	sample_if #(.W(SAMPLE_W)) dec1_s();
	sample_if #(.W(SAMPLE_W)) dec2_s();

	assign is_inj = sel_q[3:2] == SEL_GRP_DIGITAL;
	assign is_fix = sel_q[3:2] == SEL_GRP_FIXED;
	assign is_cm = sel_q == SEL_CM_TEST;

	// One modulator bit per 1 MHz enable, mapped to plus or minus full scale
	always_comb
	begin
		div_d = (div_q == DIV_W'(DIV_CYCLES - 1)) ? '0 : div_q + 1'b1;
		bit_vld_d = div_q == DIV_W'(DIV_CYCLES - 1);
		bit_dat_d = bit_vld_d ? (mod_bit ? FULL_SCALE : -FULL_SCALE) : bit_dat_q;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			div_q <= '0;
			bit_vld_q <= 1'b0;
			bit_dat_q <= '0;
		end
		else
		begin
			div_q <= div_d;
			bit_vld_q <= bit_vld_d;
			bit_dat_q <= bit_dat_d;
		end
	end

	assign bit_s.valid = bit_vld_q;
	assign bit_s.data = bit_dat_q;

	sinc3_decimator #(.RATIO(SINC1_RATIO), .W(SAMPLE_W)) u_sinc1 (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_s(bit_s),
		.out_s(dec1_s)
	);

	sinc3_decimator #(.RATIO(SINC2_RATIO), .W(SAMPLE_W)) u_sinc2 (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_s(dec1_s),
		.out_s(dec2_s)
	);

	// ------------------------------------------------------------
	// Trim, low-pass and sense register
	// ------------------------------------------------------------
	logic signed [15:0] trim_q, trim_d, lpf_q, lpf_d, x_in;
	logic trim_vld_q, trim_vld_d, lpf_vld_q, lpf_vld_d;
	iir_t st_q [6], st_d [6];
	iir_t g, y1, y2, yn;
	coef_set_t c;
	longint lin, quad, tco;

	assign x_in = is_inj ? signed'(INJ_VALUE[sel_q[1:0]]) : dec2_s.data;

	always_comb
	begin
		lin = (longint'(x_in) * longint'(signed'(trim_gain_q))) >>> TRIM_GAIN_FRAC;
		quad = (((longint'(x_in) * longint'(x_in)) >>> TRIM_QUAD_FRAC)
			* longint'(signed'(trim_quad_q))) >>> TRIM_QUAD_FRAC;
		tco = (longint'(temperature) * longint'(signed'(trim_tco_q))) >>> TRIM_TCO_FRAC;
		trim_vld_d = dec2_s.valid;
		trim_d = trim_q;
		// Injected values bypass trim so the chain settles to a fixed word
		if (dec2_s.valid)
			trim_d = is_inj ? x_in : sat16(lin + quad + tco + longint'(signed'(trim_ofs_q)));
		c = LPF_Q[lpf_1000_q];
		g = cmul(c[0], iir_t'(trim_q) <<< IIR_GUARD);
		y1 = cmul(c[1], g) + cmul(c[2], st_q[0]) + cmul(c[3], st_q[1])
			- cmul(c[7], st_q[2]) - cmul(c[8], st_q[3]);
		y2 = cmul(c[4], y1) + cmul(c[5], st_q[2]) + cmul(c[6], st_q[3])
			- cmul(c[9], st_q[4]) - cmul(c[10], st_q[5]);
		yn = cmul(c[C_NORM], y2);
		st_d = st_q;
		lpf_d = lpf_q;
		lpf_vld_d = trim_vld_q;
		if (trim_vld_q)
		begin
			st_d = '{g, st_q[0], y1, st_q[2], y2, st_q[4]};
			lpf_d = sat16(longint'((yn + (iir_t'(1) <<< (IIR_GUARD - 1))) >>> IIR_GUARD));
		end
		sense_d = sense_q;
		if (is_fix)
			sense_d = FIXED_VALUE[sel_q[1:0]];
		else if (lpf_vld_q)
			sense_d = lpf_q;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			trim_q <= '0;
			trim_vld_q <= 1'b0;
			st_q <= '{default: '0};
			lpf_q <= '0;
			lpf_vld_q <= 1'b0;
			sense_q <= 16'h0000;
		end
		else
		begin
			trim_q <= trim_d;
			trim_vld_q <= trim_vld_d;
			st_q <= st_d;
			lpf_q <= lpf_d;
			lpf_vld_q <= lpf_vld_d;
			sense_q <= sense_d;
		end
	end

	assign sense_result = sense_q;

	// ------------------------------------------------------------
	// Common-mode self-test, live fault and undervoltage
	// ------------------------------------------------------------
	cm_state_e cm_q, cm_d;
	logic [REP_W-1:0] rep_q, rep_d;
	logic exceed_q, exceed_d, over;
	logic signed [16:0] cm_diff;

	assign over = (cm_level[15] ? 17'(-cm_level) : 17'(cm_level)) > {1'b0, cm_lim_q};
	assign cm_diff = 17'(cm_level) - 17'(signed'(lpf_q));

	always_comb
	begin
		cm_d = cm_q;
		rep_d = rep_q;
		exceed_d = exceed_q;
		fail_d = fail_q;
		unique case (cm_q)
			CM_IDLE:
			begin
				if (is_cm)
				begin
					cm_d = CM_RUN;
					rep_d = '0;
					exceed_d = 1'b0;
					fail_d = 1'b0;
				end
			end
			CM_RUN, CM_FINISH:
			begin
				exceed_d = exceed_q | over;
				rep_d = rep_q + 1'b1;
				if (cm_q == CM_RUN && !is_cm)
					cm_d = CM_FINISH;
				if (rep_q == REP_W'(REPEAT_CYCLES - 1))
				begin
					fail_d = exceed_q | over;
					exceed_d = 1'b0;
					rep_d = '0;
					if (!is_cm)
						cm_d = CM_IDLE;
					else
						cm_d = CM_RUN;
				end
			end
		endcase
		run_d = (cm_d != CM_IDLE) | (cm_q != CM_IDLE) | is_inj | is_fix;
		fault_d = (cm_diff[16] ? -cm_diff : cm_diff) > {1'b0, cm_err_lim_q};
		uv_d = uv_vcc | uv_vreg | uv_vrega;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			cm_q <= CM_IDLE;
			rep_q <= '0;
			exceed_q <= 1'b0;
			fail_q <= 1'b0;
			run_q <= 1'b0;
			fault_q <= 1'b0;
			uv_q <= 1'b0;
		end
		else
		begin
			cm_q <= cm_d;
			rep_q <= rep_d;
			exceed_q <= exceed_d;
			fail_q <= fail_d;
			run_q <= run_d;
			fault_q <= fault_d;
			uv_q <= uv_d;
		end
	end

	assign test_running_flag = run_q;
	assign test_fail_flag = fail_q;
	assign common_mode_fault_bit = fault_q;
	assign serial_abort = uv_q;

endmodule

// File: pressure_signal_path_dsp_assertions.sv
// Checker: port-level properties of the pressure DSP block
module pressure_signal_path_dsp_assertions
	import pressure_dsp_pkg::*;
(
	input wire logic sys_clk, // Clock
	input wire logic rst, // Reset
	input wire logic uv_vcc, // Supply low
	input wire logic uv_vreg, // Regulator low
	input wire logic uv_vrega, // Analog regulator low
	input wire logic [7:0] avs_address, // Address
	input wire logic avs_read, // Read
	input wire logic avs_write, // Write
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte enables
	input wire logic [31:0] avs_readdata, // Read data
	input wire logic avs_waitrequest, // Wait
	input wire logic [15:0] sense_result, // Result
	input wire logic test_running_flag, // Running
	input wire logic test_fail_flag, // Fail
	input wire logic serial_abort // Abort
);
	logic lock_q;
	logic lock_d;
	logic uv_any;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// ----
	// Lock tracker
	// ----
	assign uv_any = uv_vcc | uv_vreg | uv_vrega;
	always_comb
	begin
		lock_d = lock_q;
		if (avs_write && !avs_waitrequest && avs_address == OFS_LOCK && avs_writedata[0])
			lock_d = avs_byteenable[0] | lock_q;
	end
	always_ff @(posedge sys_clk)
	begin
		lock_q <= rst ? 1'b0 : lock_d;
	end
	sequence cfg_wr_s;
		avs_write && !avs_waitrequest && avs_address == OFS_CONFIG5 && avs_byteenable[0] && !lock_q;
	endsequence
	sequence fix_wr_s;
		cfg_wr_s ##0 (avs_writedata[3:2] == SEL_GRP_FIXED);
	endsequence
	sequence test_wr_s;
		cfg_wr_s ##0 (avs_writedata[2] || avs_writedata[3:0] == SEL_CM_TEST);
	endsequence
	chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest longer than one cycle");
	chk_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest without request");
	chk_fixed_val: assert property (fix_wr_s |-> ##2
		sense_result == FIXED_VALUE[$past(avs_writedata[1:0], 2)])
		else $error("fixed pattern not in sense result");
	chk_test_run: assert property (test_wr_s |-> ##2 test_running_flag)
		else $error("running flag not set by test select");
	chk_fail_run: assert property ($rose(test_fail_flag) |-> test_running_flag)
		else $error("fail flag rose outside a running test");
	chk_lock_norun: assert property (lock_q |-> !$rose(test_running_flag))
		else $error("test started after lock");
	chk_abort_on: assert property (uv_any |=> serial_abort)
		else $error("abort missing on undervoltage");
	chk_abort_off: assert property (!uv_any |=> !serial_abort)
		else $error("abort held after supply recovery");
	chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > OFS_CM_ERR_LIMIT
		|-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule

bind pressure_signal_path_dsp pressure_signal_path_dsp_assertions u_chk (.sys_clk, .rst, .uv_vcc,
	.uv_vreg, .uv_vrega, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_readdata, .avs_waitrequest, .sense_result, .test_running_flag, .test_fail_flag,
	.serial_abort);

// File: pressure_signal_path_dsp_bench.sv
// Bench: self-checking scenarios for the pressure DSP block
module pressure_signal_path_dsp_bench
	import pressure_dsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RPT = 200;
	localparam int SETTLE = 64 * 4 * SINC1_RATIO * SINC2_RATIO;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic mod_bit;
	logic signed [15:0] cm_level = 16'sh0000;
	logic [2:0] uv = 3'b000;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic test_running_flag;
	logic test_fail_flag;
	logic serial_abort;
	logic [15:0] sense_result;
	logic common_mode_fault_bit;
	logic [31:0] rd;
	int miscompares = 0;
	int n_checks = 0;
	initial
		forever #5 sys_clk = ~sys_clk;
	modulator_model #(.DIV_CYCLES(4)) u_mod (.sys_clk(sys_clk), .rst(rst), .mod_bit(mod_bit));
	pressure_signal_path_dsp #(.REPEAT_CYCLES(RPT), .DIV_CYCLES(4)) u_dut (.sys_clk(sys_clk),
		.rst(rst), .mod_bit(mod_bit), .temperature(8'sh00), .cm_level(cm_level), .uv_vcc(uv[0]),
		.uv_vreg(uv[1]), .uv_vrega(uv[2]), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sense_result(sense_result),
		.test_running_flag(test_running_flag), .test_fail_flag(test_fail_flag),
		.common_mode_fault_bit(common_mode_fault_bit), .serial_abort(serial_abort));
	// ----
	// Shared tasks
	// ----
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Request held until the edge where waitrequest is low; data taken at that edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
		int n;
		logic w;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {16'h0000, d};
		do
		begin
			@(posedge sys_clk);
			w = avs_waitrequest;
			n++;
		end while (w !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (w !== 1'b0)
		begin
			miscompares++;
			wrap_up();
		end
	endtask
	task automatic rdr(input logic [7:0] a);
		bus(1'b0, a, 16'h0000);
	endtask
	task automatic wrr(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		rdr(OFS_CONFIG5);
		check("config", rd, 32'h0000_0000);
		rdr(OFS_STATUS);
		check("status", rd, 32'h0000_0000);
		rdr(8'h40);
		check("unmapped", rd, 32'h0000_0000);
		rdr(OFS_SENSE);
		check("sense", rd, 32'h0000_0000);
		$display("reset test done");
	endtask
	task automatic t_fixed();
		for (int i = 0; i < 4; i++)
		begin
			wrr(OFS_CONFIG5, 16'h0004 + 16'(i));
			rdr(OFS_SENSE);
			check("fixed sense", rd, {16'h0000, FIXED_VALUE[i]});
			check("fixed port", 32'(sense_result), 32'(FIXED_VALUE[i]));
			rdr(OFS_STATUS);
			check("fixed run", rd, 32'h0000_0001);
		end
		$display("fixed test done");
	endtask
	task automatic t_digital();
		logic [15:0] other [3] = '{16'h0000, 16'h0002, 16'h0008};
		for (int i = 0; i < 4; i++)
		begin
			wrr(OFS_CONFIG5, 16'h000C + 16'(i));
			rdr(OFS_STATUS);
			check("inject run", rd, 32'h0000_0001);
		end
		for (int i = 0; i < 3; i++)
		begin
			wrr(OFS_CONFIG5, other[i]);
			rdr(OFS_STATUS);
			check("normal run", rd, 32'h0000_0000);
		end
		$display("digital test done");
	endtask
	task automatic t_cm();
		int n;
		n = 0;
		wrr(OFS_CONFIG5, 16'h0001);
		rdr(OFS_STATUS);
		check("cm start", rd, 32'h0000_0001);
		cm_level <= 16'sh3000;
		repeat (RPT + 50) @(posedge sys_clk);
		rdr(OFS_STATUS);
		check("cm fail", rd, 32'h0000_0007);
		check("cm fault pin", 32'(common_mode_fault_bit), 32'h0000_0001);
		cm_level <= 16'sh0100;
		repeat (2 * RPT + 50) @(posedge sys_clk);
		rdr(OFS_STATUS);
		check("cm repeat", rd, 32'h0000_0001);
		cm_level <= 16'sh3000;
		wrr(OFS_CONFIG5, 16'h0000);
		do
		begin
			@(negedge sys_clk);
			n++;
		end while (test_running_flag !== 1'b0 && n < RPT + 20);
		if (test_running_flag !== 1'b0)
		begin
			miscompares++;
			wrap_up();
		end
		check("cm final run", 32'(test_running_flag), 32'h0000_0000);
		check("cm final fail", 32'(test_fail_flag), 32'h0000_0001);
		@(posedge sys_clk);
		cm_level <= 16'sh0000;
		$display("common-mode test done");
	endtask
	task automatic t_uv();
		for (int i = 0; i < 3; i++)
		begin
			@(posedge sys_clk);
			uv <= 3'(1 << i);
			rdr(OFS_STATUS);
			check("uv status", rd, 32'h0000_000A);
			@(negedge sys_clk);
			check("abort", 32'(serial_abort), 32'h0000_0001);
			@(posedge sys_clk);
			uv <= 3'b000;
			repeat (2) @(negedge sys_clk);
			check("resume", 32'(serial_abort), 32'h0000_0000);
		end
		$display("undervoltage test done");
	endtask
	task automatic t_lock();
		wrr(OFS_CONFIG5, 16'h0005);
		wrr(OFS_LOCK, 16'h0001);
		rdr(OFS_CONFIG5);
		check("lock clear", rd, 32'h0000_0000);
		wrr(OFS_CONFIG5, 16'h0014);
		rdr(OFS_CONFIG5);
		check("lock hold", rd, 32'h0000_0010);
		rdr(OFS_STATUS);
		check("lock run", rd, 32'h0000_0002);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		wrr(OFS_CONFIG5, 16'h0005);
		rdr(OFS_CONFIG5);
		check("unlock", rd, 32'h0000_0005);
		rdr(OFS_STATUS);
		check("unlock run", rd, 32'h0000_0001);
		$display("lock test done");
	endtask
	// Alternating modulator bits decimate to zero, so the sense word settles to the offset
	task automatic t_inject();
		wrr(OFS_TRIM_OFS, 16'h0400);
		wrr(OFS_CONFIG5, 16'h0000);
		repeat (SETTLE) @(posedge sys_clk);
		rdr(OFS_SENSE);
		check("trim sense", 32'(16'(rd[15:0] - 16'h03FF) <= 16'h0002), 32'h0000_0001);
		wrr(OFS_CONFIG5, 16'h001C);
		repeat (SETTLE) @(posedge sys_clk);
		rdr(OFS_SENSE);
		check("inject sense", 32'(16'(rd[15:0] - 16'h8170) <= 16'h0002), 32'h0000_0001);
		$display("inject test done");
	endtask
	initial
	begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_fixed();
		t_digital();
		t_cm();
		t_uv();
		t_lock();
		t_inject();
		wrap_up();
	end
endmodule

// File: sample_if.sv
// Interface: one sample stream with a valid strobe between DSP stages
interface sample_if #(parameter int W = 16);
	logic valid;
	logic signed [W-1:0] data;
	modport source(output valid, output data);
	modport sink(input valid, input data);
endinterface

// File: sinc3_decimator.sv
// Third-order sinc decimator normalised by its ratio cubed
module sinc3_decimator
	import pressure_dsp_pkg::*;
#(
	parameter int RATIO = SINC1_RATIO, // Decimation ratio
	parameter int W = SAMPLE_W // Sample width
)(
	input wire logic sys_clk, // System clock
	input wire logic rst, // Synchronous reset, active high
	sample_if.sink in_s, // Input samples
	sample_if.source out_s // Decimated samples
);
	localparam int CNT_W = $clog2(RATIO);
	localparam int AW = W + 3 * CNT_W;
	localparam int NORM_SH = 30;
	localparam longint NORM_MUL = ((longint'(1) <<< NORM_SH) + RATIO ** 3 / 2) / (RATIO ** 3);

	logic signed [AW-1:0] integ_q [3];
	logic signed [AW-1:0] integ_d [3];
	logic signed [AW-1:0] dly_q [3];
	logic signed [AW-1:0] dly_d [3];
	logic signed [AW-1:0] comb_v [4];
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic signed [W-1:0] out_q, out_d;
	logic vld_q, vld_d;
	longint scaled;

	// ------------------------------------------------------------
	// Integrators at input rate, combs at output rate
	// ------------------------------------------------------------
	always_comb
	begin
		integ_d = integ_q;
		dly_d = dly_q;
		cnt_d = cnt_q;
		out_d = out_q;
		vld_d = 1'b0;
		comb_v = '{default: '0};
		scaled = 0;
		if (in_s.valid)
		begin
			// Wrapping integrators are fine: the combs cancel the overflow
			integ_d[0] = integ_q[0] + AW'(in_s.data);
			integ_d[1] = integ_q[1] + integ_d[0];
			integ_d[2] = integ_q[2] + integ_d[1];
			cnt_d = (cnt_q == CNT_W'(RATIO - 1)) ? '0 : cnt_q + 1'b1;
			if (cnt_q == CNT_W'(RATIO - 1))
			begin
				comb_v[0] = integ_d[2];
				for (int k = 0; k < 3; k++)
				begin
					comb_v[k+1] = comb_v[k] - dly_q[k];
					dly_d[k] = comb_v[k];
				end
				scaled = (longint'(comb_v[3]) * NORM_MUL) >>> NORM_SH;
				out_d = sat16(scaled);
				vld_d = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			integ_q <= '{default: '0};
			dly_q <= '{default: '0};
			cnt_q <= '0;
			out_q <= '0;
			vld_q <= 1'b0;
		end
		else
		begin
			integ_q <= integ_d;
			dly_q <= dly_d;
			cnt_q <= cnt_d;
			out_q <= out_d;
			vld_q <= vld_d;
		end
	end

	assign out_s.valid = vld_q;
	assign out_s.data = out_q;

endmodule
